// ===== hdl/output_disable_input_detect.sv
// input detection for two active-low output-disable request pins
//
// Function
// - four-bit mode field in bits 3..0
// - code 0000 accepts on falling edge
// - codes 1..3 sample low at clk/8,16,128
// - codes 4..6 sample low at clk/1,2,4
// - four-bit field sets consecutive low samples
// - flag sets when selected condition occurs
// - flag clears by zero write after read
// - level modes clear only with pin high
// - legacy two-bit level modes need sixteen samples
//
// Added by the designer: the Wishbone interface to the registers and the register addresses.
`timescale 1ns/100ps
module output_disable_input_detect
    import odis_pkg::*;
#(
    parameter logic [RUN_W-1:0] SAMPLE_BIAS = SAMPLE_BIAS_DEF
)(
    // clock and reset
    input  logic              CORE_CLK,
    input  logic              NRST,
    // wishbone classic slave
    input  logic              WB_CYC_I,
    input  logic              WB_STB_I,
    input  logic              WB_WE_I,
    input  logic [ADDR_W-1:0] WB_ADR_I,
    input  logic [SEL_W-1:0]  WB_SEL_I,
    input  logic [DATA_W-1:0] WB_DAT_I,
    output logic [DATA_W-1:0] WB_DAT_O,
    output logic              WB_ACK_O,
    // request pins, active low
    input  logic              DISABLE_REQ_PIN_A_N,
    input  logic              DISABLE_REQ_PIN_B_N,
    // requests toward the output-disable control
    output logic              DISABLE_REQ_A,
    output logic              DISABLE_REQ_B,
    // interrupt
    output logic              IRQ
);

    logic                ack_r;
    logic [DATA_W-1:0]   rdata_r;
    logic [IRQ_W-1:0]    stat_r;
    logic [IRQ_W-1:0]    mask_r;
    logic                bus_req;
    logic                bus_wr;
    logic                bus_rd;
    logic                rd_stat;
    logic                wr_mask;
    logic [CH_N-1:0]     pin_n;
    logic [DATA_W-1:0]   pin_word;
    wire  [CH_N-1:0]     flag_vec;
    wire  [CH_N-1:0]     accept_vec;
    wire  [CH_N-1:0]     active_vec;
    wire  [CH_N-1:0]     level_vec;
    wire  [CTRL_W-1:0]   ctrl_rd [CH_N];
    wire  [RUN_W-1:0]    run_cnt [CH_N];

    assign pin_n = {DISABLE_REQ_PIN_B_N, DISABLE_REQ_PIN_A_N};

    ////////////////////////////////////////////////////////////////////////////
    // bus access: one request is taken per ack, ack drops the cycle after
    assign bus_req = WB_CYC_I && WB_STB_I && !ack_r;
    assign bus_wr  = bus_req && WB_WE_I;
    assign bus_rd  = bus_req && !WB_WE_I;
    assign rd_stat = bus_rd && (WB_ADR_I == OFS_IRQ_STAT);
    assign wr_mask = bus_wr && (WB_ADR_I == OFS_IRQ_MASK)
                     && WB_SEL_I[LANE_LO];

    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            ack_r <= 1'h0;
        end else begin
            ack_r <= bus_req;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // per-channel detector, control register and request flag
    for (genvar i = 0; i < CH_N; i++) begin : g_ch
        localparam logic [ADDR_W-1:0] CH_OFS = (i == 0) ? OFS_CTRL_A
                                                        : OFS_CTRL_B;
        logic [MODE_W-1:0] mode_r;
        logic [CNT_W-1:0]  cnt_r;
        logic              legacy_r;
        logic              flag_r;
        logic              armed_r;
        logic              wr_hit;
        logic              rd_hit;
        logic              clr_req;
        logic              clr_ok;
        logic              accept;
        logic              level_mode;
        logic              pin_high;
        logic [RUN_W-1:0]  run_count;
        logic [CTRL_W-1:0] ctrl_word;

        assign wr_hit = bus_wr && (WB_ADR_I == CH_OFS);
        assign rd_hit = bus_rd && (WB_ADR_I == CH_OFS);

        disable_req_detect #(
            .SAMPLE_BIAS (SAMPLE_BIAS)
        ) u_detect (
            .clk        (CORE_CLK),
            .nrst       (NRST),
            .pin_n      (pin_n[i]),
            .mode       (mode_r),
            .count_sel  (cnt_r),
            .legacy     (legacy_r),
            .accept     (accept),
            .level_mode (level_mode),
            .pin_high   (pin_high),
            .run_count  (run_count)
        );

        // configuration fields; byte lane 0 holds mode and count
        always_ff @(posedge CORE_CLK) begin
            if (!NRST) begin
                mode_r <= MODE_RST;
                cnt_r  <= CNT_RST;
            end else if (wr_hit && WB_SEL_I[LANE_LO]) begin
                mode_r <= WB_DAT_I[MODE_LSB +: MODE_W];
                cnt_r  <= WB_DAT_I[CNT_LSB +: CNT_W];
            end
        end

        always_ff @(posedge CORE_CLK) begin
            if (!NRST) begin
                legacy_r <= 1'h0;
            end else if (wr_hit && WB_SEL_I[LANE_HI]) begin
                legacy_r <= WB_DAT_I[LEGACY_BIT];
            end
        end

        // a read that returns the flag as one arms the clear; any write to
        // the register, or the flag going low, disarms it
        always_ff @(posedge CORE_CLK) begin
            if (!NRST) begin
                armed_r <= 1'h0;
            end else if (rd_hit && flag_r) begin
                armed_r <= 1'h1;
            end else if (wr_hit || !flag_r) begin
                armed_r <= 1'h0;
            end
        end

        assign clr_req = wr_hit && WB_SEL_I[LANE_HI]
                         && !WB_DAT_I[FLAG_BIT];
        assign clr_ok  = clr_req && armed_r
                         && (!level_mode || pin_high);

        // a new acceptance in the clearing cycle keeps the flag set
        always_ff @(posedge CORE_CLK) begin
            if (!NRST) begin
                flag_r <= 1'h0;
            end else if (accept) begin
                flag_r <= 1'h1;
            end else if (clr_ok) begin
                flag_r <= 1'h0;
            end
        end

        always_comb begin
            ctrl_word                        = {CTRL_W{1'h0}};
            ctrl_word[MODE_LSB +: MODE_W]    = mode_r;
            ctrl_word[CNT_LSB +: CNT_W]      = cnt_r;
            ctrl_word[FLAG_BIT]              = flag_r;
            ctrl_word[LEGACY_BIT]            = legacy_r;
        end

        assign ctrl_rd[i]    = ctrl_word;
        assign run_cnt[i]    = run_count;
        assign flag_vec[i]   = flag_r;
        assign accept_vec[i] = accept;
        assign active_vec[i] = level_mode;
        assign level_vec[i]  = pin_high;
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt status: sticky, cleared by reading it; a set in the read
    // cycle survives the clear
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            stat_r <= MASK_RST;
        end else begin
            stat_r <= (stat_r & ~{IRQ_W{rd_stat}}) | accept_vec;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            mask_r <= MASK_RST;
        end else if (wr_mask) begin
            mask_r <= WB_DAT_I[IRQ_W-1:0];
        end
    end

    assign IRQ = |(stat_r & mask_r);

    ////////////////////////////////////////////////////////////////////////////
    // live pin levels, level-mode flags and low-run counts
    always_comb begin
        pin_word = {DATA_W{1'h0}};
        for (int c = 0; c < CH_N; c++) begin
            pin_word[PIN_LVL_LSB + c]                  = level_vec[c];
            pin_word[PIN_ACT_LSB + c]                  = active_vec[c];
            pin_word[RUN_LSB + c*RUN_STRIDE +: RUN_W]  = run_cnt[c];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data is captured with the ack; unmapped addresses read zero
    always_ff @(posedge CORE_CLK) begin
        if (!NRST) begin
            rdata_r <= 32'h0000_0000;
        end else if (bus_rd) begin
            case (WB_ADR_I)
                OFS_CTRL_A:   rdata_r <= {{(DATA_W-CTRL_W){1'h0}},
                                          ctrl_rd[0]};
                OFS_CTRL_B:   rdata_r <= {{(DATA_W-CTRL_W){1'h0}},
                                          ctrl_rd[1]};
                OFS_IRQ_STAT: rdata_r <= {{(DATA_W-IRQ_W){1'h0}}, stat_r};
                OFS_IRQ_MASK: rdata_r <= {{(DATA_W-IRQ_W){1'h0}}, mask_r};
                OFS_PIN_STAT: rdata_r <= pin_word;
                default:      rdata_r <= 32'h0000_0000;
            endcase
        end
    end

    assign WB_DAT_O = rdata_r;
    assign WB_ACK_O = ack_r;

    ////////////////////////////////////////////////////////////////////////////
    // requests toward the disable logic track the flags
    assign DISABLE_REQ_A = flag_vec[0];
    assign DISABLE_REQ_B = flag_vec[1];

endmodule

// ===== hdl/odis_pkg.sv
// package: register map, field layout and mode codes of the disable request inputs
package odis_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // bus and block shape
    localparam int ADDR_W  = 8;
    localparam int DATA_W  = 32;
    localparam int SEL_W   = 4;
    localparam int CH_N    = 2;
    localparam int CTRL_W  = 16;
    localparam int IRQ_W   = 2;
    localparam int PRESC_W = 7;
    localparam int RUN_W   = 5;

    ////////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL_A   = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_CTRL_B   = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_PIN_STAT = 8'h10;

    ////////////////////////////////////////////////////////////////////////////
    // fields of request_input_ctrl_a / request_input_ctrl_b
    localparam int MODE_LSB   = 0;
    localparam int MODE_W     = 4;
    localparam int CNT_LSB    = 4;
    localparam int CNT_W      = 4;
    localparam int FLAG_BIT   = 12;
    localparam int LEGACY_BIT = 14;
    localparam int LANE_LO    = 0;
    localparam int LANE_HI    = 1;

    // fields of the pin status register
    localparam int PIN_LVL_LSB = 0;
    localparam int PIN_ACT_LSB = 4;
    localparam int RUN_LSB     = 8;
    localparam int RUN_STRIDE  = 8;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [MODE_W-1:0] MODE_RST = 4'h0;
    localparam logic [CNT_W-1:0]  CNT_RST  = 4'h0;
    localparam logic [IRQ_W-1:0]  MASK_RST = 2'h0;
    localparam logic [2:0]        SYNC_RST = 3'h7;

    ////////////////////////////////////////////////////////////////////////////
    // detection mode codes, four-bit field
    localparam logic [MODE_W-1:0] MODE_EDGE = 4'h0;
    localparam logic [MODE_W-1:0] MODE_D8   = 4'h1;
    localparam logic [MODE_W-1:0] MODE_D16  = 4'h2;
    localparam logic [MODE_W-1:0] MODE_D128 = 4'h3;
    localparam logic [MODE_W-1:0] MODE_D1   = 4'h4;
    localparam logic [MODE_W-1:0] MODE_D2   = 4'h5;
    localparam logic [MODE_W-1:0] MODE_D4   = 4'h6;

    // legacy two-bit codes
    localparam logic [1:0] LMODE_EDGE = 2'h0;
    localparam logic [1:0] LMODE_D8   = 2'h1;
    localparam logic [1:0] LMODE_D16  = 2'h2;
    localparam logic [1:0] LMODE_D128 = 2'h3;

    localparam logic [RUN_W-1:0] LEGACY_SAMPLES  = 5'h10;
    localparam logic [RUN_W-1:0] SAMPLE_BIAS_DEF = 5'h01;

    // prescaler masks: a sample is taken when (prescaler & mask) is zero
    localparam logic [PRESC_W-1:0] DIVM_1   = 7'h00;
    localparam logic [PRESC_W-1:0] DIVM_2   = 7'h01;
    localparam logic [PRESC_W-1:0] DIVM_4   = 7'h03;
    localparam logic [PRESC_W-1:0] DIVM_8   = 7'h07;
    localparam logic [PRESC_W-1:0] DIVM_16  = 7'h0F;
    localparam logic [PRESC_W-1:0] DIVM_128 = 7'h7F;

    typedef enum logic [1:0] {DET_OFF, DET_EDGE, DET_LEVEL} det_kind_t;

endpackage

// ===== hdl/disable_req_detect.sv
// one disable request input: pin synchroniser, mode decode and low-run counter
`timescale 1ns/100ps
module disable_req_detect
    import odis_pkg::*;
#(
    parameter logic [RUN_W-1:0] SAMPLE_BIAS = SAMPLE_BIAS_DEF
)(
    // clock and reset
    input  logic              clk,
    input  logic              nrst,
    // request pin, active low, asynchronous
    input  logic              pin_n,
    // configuration
    input  logic [MODE_W-1:0] mode,
    input  logic [CNT_W-1:0]  count_sel,
    input  logic              legacy,
    // results
    output logic              accept,
    output logic              level_mode,
    output logic              pin_high,
    output logic [RUN_W-1:0]  run_count
);

    logic [2:0]         sync_r;
    logic               level_r;
    logic               prev_r;
    logic [PRESC_W-1:0] presc_r;
    logic [RUN_W-1:0]   run_r;
    logic [RUN_W-1:0]   need;
    logic [PRESC_W-1:0] div_mask;
    det_kind_t          kind;
    logic               tick;
    logic               fall;
    logic               hit;

    ////////////////////////////////////////////////////////////////////////////
    // three stages; the level only moves once stages two and three agree
    always_ff @(posedge clk) begin
        if (!nrst) begin
            sync_r <= SYNC_RST;
        end else begin
            sync_r <= {sync_r[1:0], pin_n};
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            level_r <= 1'h1;
            prev_r  <= 1'h1;
        end else begin
            if (sync_r[1] == sync_r[2]) begin
                level_r <= sync_r[2];
            end
            prev_r <= level_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // mode decode; prohibited codes detect nothing
    always_comb begin
        kind     = DET_OFF;
        div_mask = DIVM_1;
        need     = {1'h0, count_sel} + SAMPLE_BIAS;
        if (legacy) begin
            need = LEGACY_SAMPLES;
            case (mode[1:0])
                LMODE_EDGE: kind = DET_EDGE;
                LMODE_D8: begin
                    kind     = DET_LEVEL;
                    div_mask = DIVM_8;
                end
                LMODE_D16: begin
                    kind     = DET_LEVEL;
                    div_mask = DIVM_16;
                end
                LMODE_D128: begin
                    kind     = DET_LEVEL;
                    div_mask = DIVM_128;
                end
                default: kind = DET_OFF;
            endcase
        end else begin
            case (mode)
                MODE_EDGE: kind = DET_EDGE;
                MODE_D8: begin
                    kind     = DET_LEVEL;
                    div_mask = DIVM_8;
                end
                MODE_D16: begin
                    kind     = DET_LEVEL;
                    div_mask = DIVM_16;
                end
                MODE_D128: begin
                    kind     = DET_LEVEL;
                    div_mask = DIVM_128;
                end
                MODE_D1: kind = DET_LEVEL;
                MODE_D2: begin
                    kind     = DET_LEVEL;
                    div_mask = DIVM_2;
                end
                MODE_D4: begin
                    kind     = DET_LEVEL;
                    div_mask = DIVM_4;
                end
                default: kind = DET_OFF;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // free-running prescaler: after a mode change the first sample may lag
    // by up to one division period, which keeps the logic small
    always_ff @(posedge clk) begin
        if (!nrst) begin
            presc_r <= DIVM_1;
        end else begin
            presc_r <= presc_r + 7'h01;
        end
    end

    assign tick = (presc_r & div_mask) == DIVM_1;

    // low-run counter restarts on any high sample and saturates at need
    always_ff @(posedge clk) begin
        if (!nrst) begin
            run_r <= 5'h00;
        end else if (kind != DET_LEVEL) begin
            run_r <= 5'h00;
        end else if (tick) begin
            if (level_r) begin
                run_r <= 5'h00;
            end else if (run_r != need) begin
                run_r <= run_r + 5'h01;
            end
        end
    end

    assign hit  = (kind == DET_LEVEL) && tick && !level_r
                  && ((run_r + 5'h01) == need);
    assign fall = prev_r && !level_r;

    assign accept     = (kind == DET_EDGE) ? fall : hit;
    assign level_mode = (kind == DET_LEVEL);
    assign pin_high   = level_r;
    assign run_count  = run_r;

endmodule

// ===== tb/odis_asserts.sv
// checker: bus handshake and request flag properties of the detect block
`timescale 1ns/100ps
module odis_asserts
    import odis_pkg::*;
#(
    parameter logic [RUN_W-1:0] SAMPLE_BIAS = SAMPLE_BIAS_DEF
)(
    // clock and reset
    input logic              CORE_CLK,
    input logic              NRST,
    // wishbone
    input logic              WB_CYC_I,
    input logic              WB_STB_I,
    input logic              WB_WE_I,
    input logic [ADDR_W-1:0] WB_ADR_I,
    input logic [SEL_W-1:0]  WB_SEL_I,
    input logic [DATA_W-1:0] WB_DAT_I,
    input logic [DATA_W-1:0] WB_DAT_O,
    input logic              WB_ACK_O,
    // pins, requests and interrupt
    input logic              DISABLE_REQ_PIN_A_N,
    input logic              DISABLE_REQ_PIN_B_N,
    input logic              DISABLE_REQ_A,
    input logic              DISABLE_REQ_B,
    input logic              IRQ
);
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!NRST);

    ////////////////////////////////////////////////////////////////////////////
    logic req;
    logic clr_a;
    logic clr_b;
    assign req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    // only a zero written to the flag bit may ever drop a request
    assign clr_a = req && WB_WE_I && WB_SEL_I[1] && !WB_DAT_I[FLAG_BIT]
                   && WB_ADR_I == OFS_CTRL_A;
    assign clr_b = req && WB_WE_I && WB_SEL_I[1] && !WB_DAT_I[FLAG_BIT]
                   && WB_ADR_I == OFS_CTRL_B;

    sequence rd_at(logic [ADDR_W-1:0] a);
        req && !WB_WE_I && WB_ADR_I == a;
    endsequence
    // the pin must have crossed the synchroniser before a flag rises
    sequence low_then(logic p);
        $past(!p, 3) || $past(!p, 4);
    endsequence

    ////////////////////////////////////////////////////////////////////////////
    a_ack_answers: assert property (req |=> WB_ACK_O)
        else $error("request not acknowledged in the next cycle");
    a_ack_single: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");
    a_ack_quiet: assert property (!(WB_CYC_I && WB_STB_I) |=> !WB_ACK_O)
        else $error("ack without a request");
    a_dat_holds: assert property (!(req && !WB_WE_I) |=> $stable(WB_DAT_O))
        else $error("read data moved without a read");
    a_unmapped_zero: assert property (rd_at(8'h20) |=> WB_DAT_O == '0)
        else $error("unmapped read not zero");
    a_ctrl_spare_zero: assert property (
        rd_at(OFS_CTRL_A) |=> (WB_DAT_O & 32'hFFFF_AF00) == '0)
        else $error("spare control bits not zero");
    a_flag_a_drop: assert property (
        $fell(DISABLE_REQ_A) |-> $past(clr_a))
        else $error("request a dropped without a clearing write");
    a_flag_b_drop: assert property (
        $fell(DISABLE_REQ_B) |-> $past(clr_b))
        else $error("request b dropped without a clearing write");
    a_flag_a_cause: assert property (
        $rose(DISABLE_REQ_A) |-> low_then(DISABLE_REQ_PIN_A_N))
        else $error("request a rose without a low pin");
    a_flag_b_cause: assert property (
        $rose(DISABLE_REQ_B) |-> low_then(DISABLE_REQ_PIN_B_N))
        else $error("request b rose without a low pin");
endmodule

bind output_disable_input_detect odis_asserts #(
    .SAMPLE_BIAS(SAMPLE_BIAS)
) odis_asserts_i (
    .CORE_CLK(CORE_CLK), .NRST(NRST), .WB_CYC_I(WB_CYC_I),
    .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
    .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
    .WB_ACK_O(WB_ACK_O), .DISABLE_REQ_PIN_A_N(DISABLE_REQ_PIN_A_N),
    .DISABLE_REQ_PIN_B_N(DISABLE_REQ_PIN_B_N),
    .DISABLE_REQ_A(DISABLE_REQ_A), .DISABLE_REQ_B(DISABLE_REQ_B), .IRQ(IRQ)
);

// ===== tb/fault_source.sv
// partner: external fault source pulling an active-low request pin
`timescale 1ns/100ps
module fault_source (
    // clock
    input  wire logic clk,
    // request pin, pulled up while released
    output logic      pin_n
);
    initial pin_n = 1'b1;
    task automatic lo;
        @(posedge clk);
        pin_n <= 1'b0;
    endtask
    // release before software clears a level-mode flag
    task automatic hi;
        @(posedge clk);
        pin_n <= 1'b1;
    endtask
    task automatic pull(input int n);
        if (n > 0) begin
            lo();
            repeat (n) @(posedge clk);
            pin_n <= 1'b1;
        end
    endtask
endmodule

// ===== tb/output_disable_input_detect_test.sv
// testbench: registers, detection modes, flag clearing and interrupt
`timescale 1ns/100ps
module output_disable_input_detect_test;
    import odis_pkg::*;
    logic              clk;
    logic              nrst;
    logic              cyc;
    logic              stb;
    logic              we;
    logic [ADDR_W-1:0] adr;
    logic [SEL_W-1:0]  sel;
    logic [DATA_W-1:0] dat_i;
    logic [DATA_W-1:0] dat_o;
    logic              ack;
    logic              pin_a_n;
    logic              pin_b_n;
    logic              req_a;
    logic              req_b;
    logic              irq;
    logic [DATA_W-1:0] rd_v;
    logic [DATA_W-1:0] d;
    logic [DATA_W-1:0] e;
    logic [3:0]        c;
    int                need;
    int                dv;
    int                n_mismatch;
    int                samples_checked;

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    output_disable_input_detect output_disable_input_detect_i (
        .CORE_CLK(clk), .NRST(nrst), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dat_i),
        .WB_DAT_O(dat_o), .WB_ACK_O(ack), .DISABLE_REQ_PIN_A_N(pin_a_n),
        .DISABLE_REQ_PIN_B_N(pin_b_n), .DISABLE_REQ_A(req_a),
        .DISABLE_REQ_B(req_b), .IRQ(irq)
    );
    fault_source src_a (.clk(clk), .pin_n(pin_a_n));
    fault_source src_b (.clk(clk), .pin_n(pin_b_n));

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [DATA_W-1:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic bus(input logic w, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] v);
        int k;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat_i <= v;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (ack !== 1'b1 && k < 20);
        if (k >= 20) begin
            check(ack, 1'b1);
            close_out;
        end
        rd_v = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wait_req(input int ch, input int n);
        for (int i = 0; i < n && (ch ? req_b : req_a) !== 1'b1; i++)
            @(posedge clk);
    endtask

    // read arms the flag, then a zero is written with the mode kept
    task automatic clear(input logic [ADDR_W-1:0] a, input logic [11:0] cw,
                         input logic keep);
        bus(1'b0, a, '0);
        check(rd_v[FLAG_BIT], 1'b1);
        bus(1'b1, a, {20'h0_0000, cw});
        bus(1'b0, a, '0);
        check(rd_v[FLAG_BIT], keep);
    endtask

    function automatic int div_of(input logic [3:0] m);
        case (m)
            MODE_D8:   return 8;
            MODE_D16:  return 16;
            MODE_D128: return 128;
            MODE_D2:   return 2;
            MODE_D4:   return 4;
            default:   return 1;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {cyc, stb, we, adr, dat_i} = '0;
        sel = 4'hF;
        nrst = 1'b0;
        n_mismatch = 0;
        samples_checked = 0;
        void'($urandom(32'h1f7f));
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        bus(1'b0, OFS_CTRL_A, '0);
        check(rd_v, '0);
        bus(1'b0, OFS_PIN_STAT, '0);
        check(rd_v, 32'h0000_0003);
        bus(1'b1, 8'h20, $urandom);
        bus(1'b0, 8'h20, '0);
        check(rd_v, '0);
        e = '0;
        // random byte lanes: lane 0 holds mode and count, lane 1 legacy
        for (int i = 0; i < 6; i++) begin
            d = $urandom;
            sel <= 4'($urandom);
            bus(1'b1, OFS_CTRL_B, d);
            if (sel[LANE_LO])
                e = (e & ~32'h0000_00FF) | (d & 32'h0000_00FF);
            if (sel[LANE_HI])
                e[LEGACY_BIT] = d[LEGACY_BIT];
            bus(1'b0, OFS_CTRL_B, '0);
            check(rd_v, e);
        end
        sel <= 4'hF;
        bus(1'b1, OFS_CTRL_B, '0);
        $display("test registers done");
        // edge mode on a, interrupt unmasked for a only
        bus(1'b1, OFS_IRQ_MASK, 32'h0000_0001);
        src_a.pull(6);
        wait_req(0, 12);
        check(req_a, 1'b1);
        check(irq, 1'b1);
        bus(1'b0, OFS_IRQ_STAT, '0);
        check(rd_v, 32'h0000_0001);
        check(irq, 1'b0);
        bus(1'b1, OFS_CTRL_A, '0);
        check(req_a, 1'b1);
        clear(OFS_CTRL_A, 12'h000, 1'b0);
        check(req_a, 1'b0);
        $display("test edge mode done");
        // level modes on b: short runs, restart, then a full run
        for (int m = 1; m <= 6; m++) begin
            c = (m == 4) ? 4'hF : 4'($urandom % 3);
            need = int'(c) + int'(SAMPLE_BIAS_DEF);
            dv = div_of(4'(m));
            bus(1'b1, OFS_CTRL_B, {24'h00_0000, c, 4'(m)});
            src_b.pull((need - 1) * dv);
            repeat (dv + 4) @(posedge clk);
            src_b.pull((need - 1) * dv);
            repeat (8) @(posedge clk);
            check(req_b, 1'b0);
            src_b.lo();
            wait_req(1, (need + 1) * dv + 16);
            check(req_b, 1'b1);
            check(irq, 1'b0);
            clear(OFS_CTRL_B, {4'h0, c, 4'(m)}, 1'b1);
            src_b.hi();
            repeat (8) @(posedge clk);
            clear(OFS_CTRL_B, {4'h0, c, 4'(m)}, 1'b0);
            $display("test level mode %0d done", m);
        end
        bus(1'b0, OFS_IRQ_STAT, '0);
        check(rd_v, 32'h0000_0002);
        // legacy codes 01..11 want sixteen samples whatever the count field
        dv = 1 + $urandom % 3;
        d = 32'h0000_4000 | 32'(dv) | ($urandom & 32'h0000_00F0);
        dv = div_of(4'(dv));
        bus(1'b1, OFS_CTRL_A, d);
        src_a.pull(15 * dv);
        repeat (8) @(posedge clk);
        check(req_a, 1'b0);
        src_a.lo();
        wait_req(0, 17 * dv + 16);
        check(req_a, 1'b1);
        check(irq, 1'b1);
        src_a.hi();
        repeat (8) @(posedge clk);
        clear(OFS_CTRL_A, d[11:0], 1'b0);
        $display("test legacy mode done");
        bus(1'b1, OFS_CTRL_A, 32'h0000_0007);
        src_a.pull(300);
        repeat (8) @(posedge clk);
        check(req_a, 1'b0);
        $display("test prohibited mode done");
        close_out;
    end
endmodule
